/* diag_alarm_warning_flags.sv */
// sticky alarm and warning flags with pin status and warm reset
`timescale 1ns/1ps
`include "diag_flags_cfg.svh"

module diag_alarm_warning_flags
  import diag_flags_pkg::*;
#(
  parameter int MEAS_W = 16
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  // register port
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_wdata,
  output logic      [7:0]        o_reg_rdata,
  // averaged measurements from the converter
  input  wire logic              i_meas_valid,
  input  wire logic [2:0]        i_meas_channel,
  input  wire logic [MEAS_W-1:0] i_meas_value,
  output logic                   o_conv_abort,
  output logic      [MEAS_W-1:0] o_temp_result,
  output logic      [MEAS_W-1:0] o_supply_voltage_result,
  output logic      [MEAS_W-1:0] o_laser_bias_result,
  output logic      [MEAS_W-1:0] o_transmit_power_result,
  output logic      [MEAS_W-1:0] o_receive_power_result,
  // thresholds, index = channel
  input  wire logic [MEAS_W-1:0] i_alarm_hi_limit [5],
  input  wire logic [MEAS_W-1:0] i_alarm_lo_limit [5],
  input  wire logic [MEAS_W-1:0] i_warn_hi_limit  [5],
  input  wire logic [MEAS_W-1:0] i_warn_lo_limit  [5],
  // transmit disable level
  input  wire logic              i_transmit_disable,
  // internal requests for the open-drain pins
  input  wire logic              i_fault_req,
  input  wire logic              i_los_req,
  // open-drain pins: order transmit_fault, loss_of_signal,
  // rx_rate_select_out, tx_rate_select_out, aux_general_output, general_output
  input  wire logic [5:0]        i_pin_level,
  output logic      [5:0]        o_pin_out,
  output logic      [5:0]        o_pin_oe_n,
  output logic                   o_warm_reset
);

  // ****************************************
  // state
  // ****************************************
  byte_type    alarm_0_reg, alarm_1_reg, warn_0_reg, warn_1_reg;
  byte_type    alarm_0_next, alarm_1_next, warn_0_next, warn_1_next;
  byte_type    vcfg_0_reg, vcfg_4_reg, ctrl_reg;
  logic [MEAS_W-1:0] result_reg [5];
  logic        warm_rst_reg;
  logic        txdis_d_reg;

  // ****************************************
  // decode
  // ****************************************
  wire soft_rst   = warm_rst_reg;
  wire rd_alarm_0 = i_reg_rd && i_reg_addr == `DF_IDX_ALARM_0;
  wire rd_alarm_1 = i_reg_rd && i_reg_addr == `DF_IDX_ALARM_1;
  wire rd_warn_0  = i_reg_rd && i_reg_addr == `DF_IDX_WARN_0;
  wire rd_warn_1  = i_reg_rd && i_reg_addr == `DF_IDX_WARN_1;
  wire wr_vcfg_0  = i_reg_wr && i_reg_addr == `DF_IDX_VCFG_0;
  wire wr_vcfg_4  = i_reg_wr && i_reg_addr == `DF_IDX_VCFG_4;
  wire wr_ctrl    = i_reg_wr && i_reg_addr == `DF_IDX_PIN_CTRL;
  // only clear mode zero is defined; other modes keep bits until transmit disable is released or reset
  wire clr_on_read = vcfg_4_reg[`DF_CLR_MODE_HI:`DF_CLR_MODE_LO] == 4'h0;
  wire txdis_fall = txdis_d_reg && !i_transmit_disable;

  // ****************************************
  // comparisons
  // ****************************************
  logic [4:0] a_hi, a_lo, w_hi, w_lo;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_cmp
      logic [MEAS_W-1:0] v, ah, al, wh, wl;
      // temperature uses the whole-degree byte only
      if (g == 0) begin : g_temp
        assign v  = {{(MEAS_W-8){1'b0}}, i_meas_value[MEAS_W-1 -: 8]};
        assign ah = {{(MEAS_W-8){1'b0}}, i_alarm_hi_limit[g][MEAS_W-1 -: 8]};
        assign al = {{(MEAS_W-8){1'b0}}, i_alarm_lo_limit[g][MEAS_W-1 -: 8]};
        assign wh = {{(MEAS_W-8){1'b0}}, i_warn_hi_limit[g][MEAS_W-1 -: 8]};
        assign wl = {{(MEAS_W-8){1'b0}}, i_warn_lo_limit[g][MEAS_W-1 -: 8]};
      end else begin : g_other
        assign v  = i_meas_value;
        assign ah = i_alarm_hi_limit[g];
        assign al = i_alarm_lo_limit[g];
        assign wh = i_warn_hi_limit[g];
        assign wl = i_warn_lo_limit[g];
      end
      // strict compares; not gated by transmit disable
      wire sel = i_meas_valid && !soft_rst && i_meas_channel == 3'(g);
      assign a_hi[g] = sel && (v > ah);
      assign a_lo[g] = sel && (v < al);
      assign w_hi[g] = sel && (v > wh);
      assign w_lo[g] = sel && (v < wl);
    end
  endgenerate

  wire [7:0] ev_alarm_0 = {a_hi[0], a_lo[0], a_hi[1], a_lo[1],
                           a_hi[2], a_lo[2], a_hi[3], a_lo[3]};
  wire [7:0] ev_warn_0  = {w_hi[0], w_lo[0], w_hi[1], w_lo[1],
                           w_hi[2], w_lo[2], w_hi[3], w_lo[3]};
  // receive power pair in bits 7 and 6
  wire [7:0] ev_alarm_1 = {a_hi[4], a_lo[4], 6'h00};
  wire [7:0] ev_warn_1  = {w_hi[4], w_lo[4], 6'h00};

  // per-register clear requests
  // clears come in as arguments so a lone release edge still re-evaluates the next value
  wire clr_alarm_0 = txdis_fall || (rd_alarm_0 && clr_on_read);
  wire clr_alarm_1 = txdis_fall || (rd_alarm_1 && clr_on_read);
  wire clr_warn_0  = txdis_fall || (rd_warn_0 && clr_on_read);
  wire clr_warn_1  = txdis_fall || (rd_warn_1 && clr_on_read);

  function automatic byte_type flag_upd(byte_type cur, byte_type ev, logic clr);
    byte_type held;
    held = clr ? `DF_FLAGS_RESET : cur;
    return held | ev;
  endfunction

  assign alarm_0_next = flag_upd(alarm_0_reg, ev_alarm_0, clr_alarm_0);
  assign alarm_1_next = flag_upd(alarm_1_reg, ev_alarm_1, clr_alarm_1);
  assign warn_0_next  = flag_upd(warn_0_reg,  ev_warn_0,  clr_warn_0);
  assign warn_1_next  = flag_upd(warn_1_reg,  ev_warn_1,  clr_warn_1);

  // ****************************************
  // registers
  // ****************************************
  // warm reset reloads every register default
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      alarm_0_reg <= `DF_FLAGS_RESET;
      alarm_1_reg <= `DF_FLAGS_RESET;
      warn_0_reg  <= `DF_FLAGS_RESET;
      warn_1_reg  <= `DF_FLAGS_RESET;
      vcfg_0_reg  <= `DF_VCFG_RESET;
      vcfg_4_reg  <= `DF_VCFG_RESET;
      ctrl_reg    <= `DF_CTRL_RESET;
      txdis_d_reg <= 1'b0;
    end else if (soft_rst) begin
      alarm_0_reg <= `DF_FLAGS_RESET;
      alarm_1_reg <= `DF_FLAGS_RESET;
      warn_0_reg  <= `DF_FLAGS_RESET;
      warn_1_reg  <= `DF_FLAGS_RESET;
      vcfg_0_reg  <= `DF_VCFG_RESET;
      vcfg_4_reg  <= `DF_VCFG_RESET;
      ctrl_reg    <= `DF_CTRL_RESET;
      txdis_d_reg <= 1'b0;
    end else begin
      alarm_0_reg <= alarm_0_next;
      alarm_1_reg <= alarm_1_next;
      warn_0_reg  <= warn_0_next;
      warn_1_reg  <= warn_1_next;
      if (wr_vcfg_0) vcfg_0_reg <= i_reg_wdata;
      if (wr_vcfg_4) vcfg_4_reg <= i_reg_wdata;
      if (wr_ctrl)   ctrl_reg   <= i_reg_wdata;
      txdis_d_reg <= i_transmit_disable;
    end
  end

  // reset bit lives one cycle and clears itself
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) warm_rst_reg <= 1'b0;
    else           warm_rst_reg <= !warm_rst_reg && wr_vcfg_0 && i_reg_wdata[`DF_RST_BIT];
  end

  // results update regardless of transmit disable
  // warm reset discards the in-flight value
  generate
    for (g = 0; g < 5; g++) begin : g_res
      always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst)      result_reg[g] <= '0;
        else if (soft_rst)  result_reg[g] <= '0;
        else if (i_meas_valid && i_meas_channel == 3'(g)) result_reg[g] <= i_meas_value;
      end
    end
  endgenerate

  assign o_conv_abort            = soft_rst;
  assign o_warm_reset            = soft_rst;
  assign o_temp_result           = result_reg[0];
  assign o_supply_voltage_result = result_reg[1];
  assign o_laser_bias_result     = result_reg[2];
  assign o_transmit_power_result = result_reg[3];
  assign o_receive_power_result  = result_reg[4];

  // ****************************************
  // pins
  // ****************************************
  // fault and loss released during warm reset
  wire [5:0] pin_assert = {i_fault_req && !soft_rst, i_los_req && !soft_rst, ctrl_reg[3:0]};
  // drive low only; external drivers may share the wire
  assign o_pin_out  = 6'h00;
  assign o_pin_oe_n = ~pin_assert;

  // ****************************************
  // read mux
  // ****************************************
  // status shows the sensed pin level
  wire [7:0] pin_stat = {2'b00, i_pin_level};
  always_comb begin
    unique case (i_reg_addr)
      `DF_IDX_ALARM_0:  o_reg_rdata = alarm_0_reg;
      `DF_IDX_ALARM_1:  o_reg_rdata = alarm_1_reg;
      `DF_IDX_WARN_0:   o_reg_rdata = warn_0_reg;
      `DF_IDX_WARN_1:   o_reg_rdata = warn_1_reg;
      `DF_IDX_VCFG_0:   o_reg_rdata = vcfg_0_reg;
      `DF_IDX_VCFG_4:   o_reg_rdata = vcfg_4_reg;
      `DF_IDX_PIN_STAT: o_reg_rdata = pin_stat;
      `DF_IDX_PIN_CTRL: o_reg_rdata = ctrl_reg;
      default:          o_reg_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  // bias high alarm
  a_bias_high_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h2 && !soft_rst && i_meas_value > i_alarm_hi_limit[2])
    |=> alarm_0_reg[3]) else $error("bias high alarm not set");

  a_temp_high_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h0 && !soft_rst
     && i_meas_value[MEAS_W-1 -: 8] > i_alarm_hi_limit[0][MEAS_W-1 -: 8])
    |=> alarm_0_reg[7]) else $error("temperature high alarm not set");

  a_supply_low_warn: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h1 && !soft_rst && i_meas_value < i_warn_lo_limit[1])
    |=> warn_0_reg[4]) else $error("supply low warning not set");

  a_equal_no_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h3 && i_meas_value == i_warn_lo_limit[3]
     && !warn_0_reg[0] && !txdis_fall) |=> !warn_0_reg[0]) else $error("equal value set flag");

  a_temp_byte_only: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h0 && !alarm_0_reg[7]
     && i_meas_value[MEAS_W-1 -: 8] == i_alarm_hi_limit[0][MEAS_W-1 -: 8])
    |=> !alarm_0_reg[7]) else $error("temperature low byte used");

  a_rx_low_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h4 && !soft_rst && i_meas_value < i_warn_lo_limit[4])
    |=> warn_1_reg[`DF_RX_LO_BIT]) else $error("rx low warning not set");

  a_rx_high_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h4 && !soft_rst && i_meas_value > i_alarm_hi_limit[4])
    |=> alarm_1_reg[`DF_RX_HI_BIT]) else $error("rx high alarm not set");

  a_warn_unmasked: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ev_warn_0 != 8'h00 |=> (warn_0_reg & $past(ev_warn_0)) == $past(ev_warn_0))
    else $error("warning event masked");

  a_read_clears: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rd_warn_0 && clr_on_read && ev_warn_0 == 8'h00 && !soft_rst) |=> warn_0_reg == 8'h00)
    else $error("read did not clear");

  a_sticky_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!rd_alarm_1 && !txdis_fall && !soft_rst)
    |=> (alarm_1_reg & $past(alarm_1_reg)) == $past(alarm_1_reg))
    else $error("alarm bit dropped without a clear");

  a_set_beats_read: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rd_alarm_0 && ev_alarm_0 != 8'h00)
    |=> (alarm_0_reg & $past(ev_alarm_0)) == $past(ev_alarm_0)) else $error("event lost");

  a_result_tracks: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_meas_valid && i_meas_channel == 3'h3 && !soft_rst)
    |=> o_transmit_power_result == $past(i_meas_value)) else $error("result not updated");

  a_txdis_events: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_transmit_disable && ev_alarm_0 != 8'h00)
    |=> (alarm_0_reg & $past(ev_alarm_0)) == $past(ev_alarm_0))
    else $error("event lost while disabled");

  a_txdis_release: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (txdis_fall && ev_alarm_1 == 8'h00 && ev_warn_1 == 8'h00) |=> alarm_1_reg == 8'h00
    && warn_1_reg == 8'h00) else $error("release did not clear");

  a_warm_start: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_vcfg_0 && i_reg_wdata[`DF_RST_BIT] && !soft_rst) |=> soft_rst)
    else $error("warm reset not started");

  a_warm_defaults: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    soft_rst |=> alarm_0_reg == 8'h00 && vcfg_4_reg == 8'h00 && ctrl_reg == 8'h00
    && result_reg[0] == '0) else $error("warm reset left state");

  a_results_dropped: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    soft_rst |=> o_transmit_power_result == '0 && o_receive_power_result == '0
    && o_supply_voltage_result == '0) else $error("result kept through warm reset");

  a_rst_self_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    soft_rst |=> !soft_rst) else $error("reset bit stuck");

  a_pins_released: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    soft_rst |-> o_pin_oe_n[5] && o_pin_oe_n[4]) else $error("pins driven in reset");

  a_stat_level: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_reg_addr == `DF_IDX_PIN_STAT |-> o_reg_rdata[5:0] == i_pin_level)
    else $error("status not pin level");

endmodule

/* diag_flags_cfg.svh */
// constants for the alarm and warning flag block
`ifndef DIAG_FLAGS_CFG_SVH
`define DIAG_FLAGS_CFG_SVH
`define DF_IDX_ALARM_0   8'h00
`define DF_IDX_ALARM_1   8'h01
`define DF_IDX_WARN_0    8'h02
`define DF_IDX_WARN_1    8'h03
`define DF_IDX_VCFG_0    8'h04
`define DF_IDX_VCFG_4    8'h05
`define DF_IDX_PIN_STAT  8'h06
`define DF_IDX_PIN_CTRL  8'h07
`define DF_RST_BIT       7
`define DF_CLR_MODE_HI   7
`define DF_CLR_MODE_LO   4
`define DF_RX_HI_BIT     7
`define DF_RX_LO_BIT     6
`define DF_FLAGS_RESET   8'h00
`define DF_VCFG_RESET    8'h00
`define DF_CTRL_RESET    8'h00
`endif

/* diag_flags_pkg.sv */
// types for the alarm and warning flag block
package diag_flags_pkg;
  typedef logic [7:0] byte_type;
  // measurement order: temperature, supply, bias, tx power, rx power
  typedef enum logic [2:0] {
    CH_TEMP   = 3'h0,
    CH_SUPPLY = 3'h1,
    CH_BIAS   = 3'h2,
    CH_TXPWR  = 3'h3,
    CH_RXPWR  = 3'h4
  } channel_type;
endpackage

/* diag_pin_model.sv */
// open-drain pin wiring with pull-ups and outside drivers
`timescale 1ns/1ps

module diag_pin_model (
  input  wire logic [5:0] i_pin_out,
  input  wire logic [5:0] i_pin_oe_n,
  input  wire logic [5:0] i_ext_low,
  output logic      [5:0] o_pin_level
);
  // ****************
  // wired-and pins
  // ****************
  // shared pull-up
  // a pin pulled by nobody reads high, never the last driven value
  assign o_pin_level = ~((~i_pin_oe_n & ~i_pin_out) | i_ext_low);
endmodule

/* test_diag_alarm_warning_flags.sv */
// self-checking bench for the alarm and warning flag block
`timescale 1ns/1ps

module test_diag_alarm_warning_flags;
  import diag_flags_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        mv = 1'b0;
  logic [2:0]  mch = 3'h0;
  logic [15:0] mval = 16'h0000;
  logic        abort;
  logic [15:0] res [5];
  logic [15:0] ahi [5];
  logic [15:0] alo [5];
  logic [15:0] whi [5];
  logic [15:0] wlo [5];
  logic        txd = 1'b0;
  logic        freq = 1'b1;
  logic        lreq = 1'b0;
  logic [5:0]  lvl;
  logic [5:0]  pout;
  logic [5:0]  oe_n;
  logic [5:0]  ext = 6'h00;
  logic        warm;
  int          err_count = 0;
  int          checked = 0;

  always #25 clk = ~clk;
  initial for (int k = 0; k < 5; k++) begin
    ahi[k] = 16'h8000;
    alo[k] = 16'h2000;
    whi[k] = 16'h6000;
    wlo[k] = 16'h3000;
  end

  diag_alarm_warning_flags u_diag_alarm_warning_flags (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_meas_valid(mv), .i_meas_channel(mch),
    .i_meas_value(mval), .o_conv_abort(abort), .o_temp_result(res[0]),
    .o_supply_voltage_result(res[1]), .o_laser_bias_result(res[2]),
    .o_transmit_power_result(res[3]), .o_receive_power_result(res[4]),
    .i_alarm_hi_limit(ahi), .i_alarm_lo_limit(alo), .i_warn_hi_limit(whi),
    .i_warn_lo_limit(wlo), .i_transmit_disable(txd), .i_fault_req(freq), .i_los_req(lreq),
    .i_pin_level(lvl), .o_pin_out(pout), .o_pin_oe_n(oe_n), .o_warm_reset(warm));

  diag_pin_model u_diag_pin_model (
    .i_pin_out(pout), .i_pin_oe_n(oe_n), .i_ext_low(ext), .o_pin_level(lvl));

  // ****************
  // shared tasks
  // ****************
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(negedge clk) chk("rdata", rdata, exp);
    @(posedge clk) rd <= 1'b0;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic meas(input logic [2:0] c, input logic [15:0] v);
    @(posedge clk) begin mch <= c; mval <= v; mv <= 1'b1; end
    @(posedge clk) mv <= 1'b0;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic s_levels();
    for (int c = 0; c < 4; c++) meas(c[2:0], 16'h9000);
    reg_rd(8'h00, 8'hAA);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h02, 8'hAA);
    for (int c = 0; c < 4; c++) meas(c[2:0], 16'h1000);
    reg_rd(8'h00, 8'h55);
    reg_rd(8'h02, 8'h55);
    meas(3'h2, 16'h8000);
    meas(3'h2, 16'h2000);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h02, 8'h0C);
    meas(3'h3, 16'h3000);
    reg_rd(8'h02, 8'h00);
    meas(3'h0, 16'h80FF);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h02, 8'h80);
    chk("temp_result", res[0], 16'h80FF);
    meas(3'h4, 16'h9000);
    reg_rd(8'h01, 8'h80);
    reg_rd(8'h03, 8'h80);
    meas(3'h4, 16'h1000);
    reg_rd(8'h01, 8'h40);
    reg_rd(8'h03, 8'h40);
    chk("rx_result", res[4], 16'h1000);
  endtask

  task automatic s_race_mode();
    @(posedge clk) begin addr <= 8'h00; rd <= 1'b1; mv <= 1'b1; mch <= 3'h2; mval <= 16'h9000; end
    @(posedge clk) begin rd <= 1'b0; mv <= 1'b0; end
    reg_rd(8'h00, 8'h08);
    reg_wr(8'h05, 8'h10);
    meas(3'h1, 16'h9000);
    reg_rd(8'h00, 8'h20);
    reg_rd(8'h00, 8'h20);
    reg_wr(8'h05, 8'h00);
    reg_rd(8'h00, 8'h20);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h02, 8'h28);
    chk("supply_result", res[1], 16'h9000);
  endtask

  task automatic s_txdis();
    @(posedge clk) txd <= 1'b1;
    meas(3'h3, 16'h9000);
    @(negedge clk) chk("tx_result", res[3], 16'h9000);
    reg_rd(8'h02, 8'h02);
    reg_rd(8'h00, 8'h02);
    meas(3'h3, 16'h1000);
    @(posedge clk) txd <= 1'b0;
    repeat (2) @(posedge clk);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h02, 8'h00);
  endtask

  task automatic s_pins();
    reg_wr(8'h07, 8'h0F);
    chk("pin_out", pout, 6'h00);
    @(negedge clk) chk("oe_n", oe_n, 6'h10);
    reg_rd(8'h06, 8'h10);
    reg_wr(8'h07, 8'h00);
    @(posedge clk) ext <= 6'h01;
    reg_rd(8'h06, 8'h1E);
  endtask

  task automatic s_warm();
    int n;
    @(posedge clk) lreq <= 1'b1;
    reg_wr(8'h05, 8'h30);
    reg_wr(8'h07, 8'h0F);
    meas(3'h2, 16'h9000);
    reg_wr(8'h04, 8'h80);
    n = 0;
    while (warm !== 1'b1) begin
      @(negedge clk);
      if (++n > 4) begin
        chk("warm", warm, 1'b1);
        end_of_test();
      end
    end
    chk("oe_n_warm", oe_n[5:4], 2'b11);
    chk("abort", abort, 1'b1);
    @(negedge clk) chk("bias_result", res[2], 16'h0000);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h04, 8'h00);
    reg_rd(8'h05, 8'h00);
    reg_rd(8'h07, 8'h00);
    chk("oe_n_after", oe_n, 6'h0F);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) reg_rd(a[7:0], 8'h00);
    reg_rd(8'h20, 8'h00);
    s_levels();
    s_race_mode();
    s_txdis();
    s_pins();
    s_warm();
    end_of_test();
  end
endmodule
